// File: lsac_pkg.sv
package lsac_pkg;
  // field positions within the upper half of the control byte
  localparam int unsigned LSAC_BIT_LANE_ORDER = 7;
  localparam int unsigned LSAC_BIT_POLARITY = 6;
  localparam int unsigned LSAC_BIT_RESERVED = 5;
  localparam int unsigned LSAC_BIT_ACT_EN = 4;
  // values after reset, before the straps are taken
  localparam logic LSAC_RST_LANE_ORDER = 1'b0;
  localparam logic LSAC_RST_POLARITY = 1'b0;
  localparam logic LSAC_RST_ACT_EN = 1'b0;
  // register width
  localparam int unsigned LSAC_REG_W = 8;
  // lanes carried through the swap and polarity logic
  localparam int unsigned LSAC_LANES = 4;
  // strap capture: cycles after reset release before straps are latched
  localparam logic [1:0] LSAC_STRAP_WAIT = 2'h2;
endpackage : lsac_pkg

// File: lsac_lane_swap_activity_control.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - lane-order bit 1 reverses input lanes in redriver and retimer operation; 0 passes them.
// - lane-order bit resets to zero, no reordering.
// - polarity bit 1 inverts data and clock lanes, only in retimer mode.
// - polarity bit 0 leaves lane polarity unchanged.
// - lane-order and polarity bits load from the shared swap/polarity strap.
// - with config-select strap 0, serial writes to strap fields are discarded.
// - activity-enable bit turns the clock-lane activity detector on or off.
// - activity-enable 0 (default) keeps detector off, receiver always in normal operation.
// - activity-enable 1 puts receiver in standby when no valid data is detected.
// - activity-enable loads from its strap; serial writes ignored when config-select is 0.
module lsac_lane_swap_activity_control
  import lsac_pkg::*;
#(
  parameter int unsigned LANES = LSAC_LANES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // pin straps, asynchronous
  input wire logic laneOrderPolarityStrap,
  input wire logic clockActivityStandbyEnableStrap,
  input wire logic serialConfigSelectStrap,
  // serial host register port
  input wire logic regWrite,
  input wire logic [LSAC_REG_W-1:0] regWrData,
  output logic [LSAC_REG_W-1:0] regRdData,
  // datapath control
  input wire logic retimerMode,
  input wire logic [LANES-1:0] laneIn,
  output logic [LANES-1:0] laneOut,
  // clock detector
  input wire logic clockDataValid,
  output logic clockDetectorOn,
  output logic receiverStandby
);

  // two-stage synchronisers for the three straps
  logic [2:0] strapMeta_q, strapSync_q;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      strapMeta_q <= 3'h0;
      strapSync_q <= 3'h0;
    end else begin
      strapMeta_q <= {serialConfigSelectStrap, clockActivityStandbyEnableStrap,
                      laneOrderPolarityStrap};
      strapSync_q <= strapMeta_q;
    end
  end

  // control state: wait counter lets synchronisers fill before straps are caught
  logic [1:0] waitCnt_q, waitCnt_d;
  logic strapDone_q, strapDone_d;
  logic cfgSel_q, cfgSel_d;
  logic laneOrder_q, laneOrder_d;
  logic polarity_q, polarity_d;
  logic actEn_q, actEn_d;

  always_comb begin
    waitCnt_d = waitCnt_q;
    strapDone_d = strapDone_q;
    cfgSel_d = cfgSel_q;
    laneOrder_d = laneOrder_q;
    polarity_d = polarity_q;
    actEn_d = actEn_q;
    if (!strapDone_q) begin
      if (waitCnt_q == LSAC_STRAP_WAIT) begin
        strapDone_d = 1'b1;
        // select strap latched once; a pin moving mid-run cannot change write rights
        cfgSel_d = strapSync_q[2];
        laneOrder_d = strapSync_q[0];
        polarity_d = strapSync_q[0];
        actEn_d = strapSync_q[1];
      end else begin
        waitCnt_d = waitCnt_q + 2'h1;
      end
    end else if (regWrite && cfgSel_q) begin
      // reserved bit is never stored, so writes to it vanish
      laneOrder_d = regWrData[LSAC_BIT_LANE_ORDER];
      polarity_d = regWrData[LSAC_BIT_POLARITY];
      actEn_d = regWrData[LSAC_BIT_ACT_EN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      waitCnt_q <= 2'h0;
      strapDone_q <= 1'b0;
      cfgSel_q <= 1'b0;
      laneOrder_q <= LSAC_RST_LANE_ORDER;
      polarity_q <= LSAC_RST_POLARITY;
      actEn_q <= LSAC_RST_ACT_EN;
    end else begin
      waitCnt_q <= waitCnt_d;
      strapDone_q <= strapDone_d;
      cfgSel_q <= cfgSel_d;
      laneOrder_q <= laneOrder_d;
      polarity_q <= polarity_d;
      actEn_q <= actEn_d;
    end
  end

  // read-back; lower nibble belongs to other fields, reads zero here
  always_comb begin
    regRdData = '0;
    regRdData[LSAC_BIT_LANE_ORDER] = laneOrder_q;
    regRdData[LSAC_BIT_POLARITY] = polarity_q;
    regRdData[LSAC_BIT_RESERVED] = 1'b0;
    regRdData[LSAC_BIT_ACT_EN] = actEn_q;
  end

  // lane reorder then polarity; polarity only honoured in retimer mode
  logic [LANES-1:0] swapped;
  logic [LANES-1:0] laneOut_d;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_swap
      assign swapped[g] = laneOrder_q ? laneIn[LANES-1-g] : laneIn[g];
    end
  endgenerate
  assign laneOut_d = (polarity_q && retimerMode) ? ~swapped : swapped;

  // standby only with detector enabled and no valid data seen
  logic standby_d;
  assign standby_d = actEn_q && !clockDataValid;

  logic [LANES-1:0] laneOut_q;
  logic standby_q, detOn_q;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      laneOut_q <= '0;
      standby_q <= 1'b0;
      detOn_q <= 1'b0;
    end else begin
      laneOut_q <= laneOut_d;
      standby_q <= standby_d;
      detOn_q <= actEn_q;
    end
  end
  assign laneOut = laneOut_q;
  assign receiverStandby = standby_q;
  assign clockDetectorOn = detOn_q;

  // reference lane reversal for the checks, written apart from the datapath loop
  function automatic logic [LANES-1:0] reverseLanes(input logic [LANES-1:0] v);
    logic [LANES-1:0] r;
    for (int i = 0; i < LANES; i++) begin
      r[i] = v[LANES-1-i];
    end
    return r;
  endfunction

  a_lane_swap_map: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> laneOut == (($past(polarity_q) && $past(retimerMode)) ?
      ~($past(laneOrder_q) ? reverseLanes($past(laneIn)) : $past(laneIn)) :
      ($past(laneOrder_q) ? reverseLanes($past(laneIn)) : $past(laneIn))))
    else $error("lane output mismatch");
  a_reset_order_zero: assert property (@(posedge core_clk)
    !$past(nrst) |-> !laneOrder_q && !polarity_q && !actEn_q)
    else $error("fields not zero after reset");
  a_polarity_retimer: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) && !$past(retimerMode) && !$past(laneOrder_q) |-> laneOut == $past(laneIn))
    else $error("polarity applied outside retimer mode");
  a_polarity_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) && !$past(polarity_q) && !$past(laneOrder_q) |-> laneOut == $past(laneIn))
    else $error("polarity changed while disabled");
  a_strap_load: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(strapDone_q) |-> laneOrder_q == $past(strapSync_q[0])
      && polarity_q == $past(strapSync_q[0]) && actEn_q == $past(strapSync_q[1]))
    else $error("strap not loaded");
  a_write_blocked: assert property (@(posedge core_clk) disable iff (!nrst)
    strapDone_q && !cfgSel_q ##1 1'b1 |-> $stable(laneOrder_q) && $stable(polarity_q))
    else $error("write taken with serial control off");
  a_detector_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> clockDetectorOn == $past(actEn_q))
    else $error("detector enable mismatch");
  a_no_standby_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !actEn_q ##1 1'b1 |-> !receiverStandby)
    else $error("standby while detector off");
  a_standby_entry: assert property (@(posedge core_clk) disable iff (!nrst)
    actEn_q && !clockDataValid ##1 1'b1 |-> receiverStandby)
    else $error("standby not entered");
  a_act_write_blocked: assert property (@(posedge core_clk) disable iff (!nrst)
    strapDone_q && !cfgSel_q ##1 1'b1 |-> $stable(actEn_q))
    else $error("activity enable written with serial control off");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    regRdData[LSAC_BIT_RESERVED] == 1'b0)
    else $error("reserved bit not zero");

  // permitted writes land, and each half of the lane map on its own
  a_write_taken: assert property (@(posedge core_clk) disable iff (!nrst)
    strapDone_q && cfgSel_q && regWrite |=>
      laneOrder_q == $past(regWrData[LSAC_BIT_LANE_ORDER])
      && polarity_q == $past(regWrData[LSAC_BIT_POLARITY]))
    else $error("permitted write not stored");
  a_act_write_taken: assert property (@(posedge core_clk) disable iff (!nrst)
    strapDone_q && cfgSel_q && regWrite |=> actEn_q == $past(regWrData[LSAC_BIT_ACT_EN]))
    else $error("permitted activity enable write not stored");
  a_lane_reverse: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) && $past(laneOrder_q) && !$past(polarity_q) |->
      laneOut == reverseLanes($past(laneIn)))
    else $error("lanes not reversed");
  a_polarity_invert: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) && $past(polarity_q) && $past(retimerMode) && !$past(laneOrder_q) |->
      laneOut == ~$past(laneIn))
    else $error("polarity not inverted in retimer mode");
  // reset values, and nothing moves before the straps are caught
  a_reset_outputs: assert property (@(posedge core_clk)
    !$past(nrst) |-> laneOut == '0 && !receiverStandby && !clockDetectorOn)
    else $error("outputs not cleared by reset");
  a_pre_load_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !strapDone_q |-> !laneOrder_q && !polarity_q && !actEn_q)
    else $error("fields moved before strap load");
  a_detector_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !actEn_q ##1 1'b1 |-> !clockDetectorOn)
    else $error("detector on while disabled");
  a_standby_exit: assert property (@(posedge core_clk) disable iff (!nrst)
    clockDataValid ##1 1'b1 |-> !receiverStandby)
    else $error("standby with valid data present");

endmodule // lsac_lane_swap_activity_control
`default_nettype wire

// File: lsac_host.sv
`timescale 1ns/1ps
`default_nettype none
// serial config host: write strobe held until the next put, no handshake back
module lsac_host
  import lsac_pkg::*;
(
  // host side
  input wire logic core_clk,
  output logic regWrite,
  output logic [LSAC_REG_W-1:0] regWrData
);
  // called just after a rising edge, so it lands as a non-blocking update
  task automatic put(input logic en, input logic [LSAC_REG_W-1:0] d);
    regWrite <= en;
    regWrData <= d;
  endtask
endmodule // lsac_host
`default_nettype wire

// File: lsac_lane_swap_activity_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module lsac_lane_swap_activity_control_bench;
  import lsac_pkg::*;
  logic core_clk, nrst, strapLop, strapAct, strapSel, rtm, valid, wr, det, stby;
  logic [3:0] lin, lout;
  logic [7:0] wd, rd, mdl;
  logic [13:0] q[$], e;
  int mismatches = 0, total_checks = 0, seed = 20681;
  lsac_host u_lsac_host(.core_clk(core_clk), .regWrite(wr), .regWrData(wd));
  lsac_lane_swap_activity_control u_lsac_lane_swap_activity_control(.core_clk(core_clk),
    .nrst(nrst), .laneOrderPolarityStrap(strapLop), .clockActivityStandbyEnableStrap(strapAct),
    .serialConfigSelectStrap(strapSel), .regWrite(wr), .regWrData(wd), .regRdData(rd),
    .retimerMode(rtm), .laneIn(lin), .laneOut(lout), .clockDataValid(valid),
    .clockDetectorOn(det), .receiverStandby(stby));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // reverse first, then invert only in retimer mode
  function automatic logic [3:0] lanes(input logic [3:0] d, input logic [7:0] r, input logic m);
    logic [3:0] v;
    v = r[7] ? {d[0], d[1], d[2], d[3]} : d;
    return (r[6] && m) ? ~v : v;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // reset with given straps, then random writes and lane traffic
  task automatic phase(input logic l, input logic a, input logic s);
    logic [7:0] pre, pd;
    logic [3:0] pin;
    logic pm, pv, pw;
    strapLop <= l; strapAct <= a; strapSel <= s; nrst <= 1'b0;
    lin <= 4'h0; rtm <= 1'b0; valid <= 1'b1; u_lsac_host.put(1'b0, 8'h00);
    pin = 4'h0; pm = 1'b0; pv = 1'b1; pw = 1'b0; pd = 8'h00;
    repeat (6) begin
      @(posedge core_clk);
      q.push_back(14'h0000);
    end
    // a write held across the strap load must be dropped
    nrst <= 1'b1;
    u_lsac_host.put(1'b1, 8'hD0);
    repeat (3) @(posedge core_clk);
    u_lsac_host.put(1'b0, 8'h00);
    repeat (5) @(posedge core_clk);
    mdl = {l, l, 1'b0, a, 4'h0};
    repeat (40) begin
      @(posedge core_clk);
      pre = mdl;
      if (pw && s) mdl = {pd[7:6], 1'b0, pd[4], 4'h0};
      q.push_back({mdl, lanes(pin, pre, pm), pre[4], pre[4] & ~pv});
      pin = 4'($random(seed)); pm = 1'($random(seed)); pv = 1'($random(seed));
      pw = 1'($random(seed)); pd = 8'($random(seed));
      lin <= pin; rtm <= pm; valid <= pv; u_lsac_host.put(pw, pd);
    end
    // let the last random inputs land before the next reset drives them
    @(posedge core_clk);
    $display("phase done swapStrap=%0b actStrap=%0b select=%0b", l, a, s);
  endtask
  // results settle by the falling edge; oldest note first
  always @(negedge core_clk) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      `CHK({rd, lout, det, stby}, e)
    end
  end
  initial begin
    phase(1'b1, 1'b0, 1'b1);
    phase(1'b0, 1'b1, 1'b0);
    phase(1'b1, 1'b1, 1'b1);
    @(negedge core_clk);
    final_report;
  end
  // about 170 cycles expected; cut off well past that
  initial begin
    #25000;
    mismatches++;
    final_report;
  end
endmodule // lsac_lane_swap_activity_control_bench
`default_nettype wire
